// ---- logic/dbp_defs.svh ----
`ifndef DBP_DEFS_SVH
`define DBP_DEFS_SVH

// ==========================================================
// register indices (one word each, byte address = index)
`define DBP_ADDR_C_DATA 4'h0
`define DBP_ADDR_C_DIR 4'h1
`define DBP_ADDR_D_DATA 4'h2
`define DBP_ADDR_D_DIR 4'h3
`define DBP_ADDR_C_ANALOG 4'h4
`define DBP_ADDR_D_ANALOG 4'h5
`define DBP_ADDR_STATUS 4'h6

// ==========================================================
// reset values
`define DBP_DIR_RESET 8'hFF
`define DBP_ANALOG_RESET 8'h00
`define DBP_DATA_POR 8'h00

// ==========================================================
// field positions
`define DBP_LOW_PWR_MASK 8'h03
`define DBP_STAT_LOW_PWR_BIT 0
`define DBP_STAT_COLD_BIT 1

`endif

// ---- logic/dbp_pkg.sv ----
`default_nettype none

// ==========================================================
// shared types
package dbp_pkg;
  typedef logic [7:0] dbp_byte_type;
  // where a pin takes its output from
  typedef enum logic [1:0] {
    DBP_SRC_LATCH,
    DBP_SRC_PERIPH,
    DBP_SRC_ANALOG
  } dbp_src_type;
endpackage

`default_nettype wire

// ---- logic/dbp_pin_mux.sv ----
`default_nettype none

// ==========================================================
// per-port output steering: latch versus peripheral
module dbp_pin_mux #(
  parameter int WIDTH = 8
) (
  // port state
  input wire logic [WIDTH-1:0] latch_i,
  input wire logic [WIDTH-1:0] dir_i,
  // peripheral claims
  input wire logic [WIDTH-1:0] per_sel_i,
  input wire logic [WIDTH-1:0] per_out_i,
  input wire logic [WIDTH-1:0] per_oe_i,
  // resolved pin drive
  output logic [WIDTH-1:0] out_o,
  output logic [WIDTH-1:0] oe_o
);
  always_comb begin
    for (int i = 0; i < WIDTH; i++) begin
      if (per_sel_i[i]) begin
        out_o[i] = per_out_i[i];
        oe_o[i] = per_oe_i[i];
      end else begin
        out_o[i] = latch_i[i];
        oe_o[i] = ~dir_i[i];
      end
    end
  end
endmodule

`default_nettype wire

// ---- logic/dbp_read_mux.sv ----
`default_nettype none
`include "dbp_defs.svh"

// ==========================================================
// read data selection for the register port
module dbp_read_mux (
  // register state
  input wire logic [3:0] addr_i,
  input wire logic [7:0] c_pins_i,
  input wire logic [7:0] d_pins_i,
  input wire logic [7:0] c_dir_i,
  input wire logic [7:0] d_dir_i,
  input wire logic [7:0] c_ana_i,
  input wire logic [7:0] d_ana_i,
  input wire logic [7:0] status_i,
  input wire logic lp_mode_i,
  // selected word
  output logic [7:0] data_o
);
  always_comb begin
    unique case (addr_i)
      `DBP_ADDR_C_DATA: data_o = c_pins_i & ~c_ana_i;
      `DBP_ADDR_D_DATA: data_o = d_pins_i & ~d_ana_i;
      `DBP_ADDR_C_DIR:
        data_o = lp_mode_i ? (c_dir_i | `DBP_LOW_PWR_MASK) : c_dir_i;
      `DBP_ADDR_D_DIR: data_o = d_dir_i;
      `DBP_ADDR_C_ANALOG: data_o = c_ana_i;
      `DBP_ADDR_D_ANALOG: data_o = d_ana_i;
      `DBP_ADDR_STATUS: data_o = status_i;
      default: data_o = 8'h00;
    endcase
  end
endmodule

`default_nettype wire

// ---- logic/dbp_top.sv ----
`default_nettype none
`include "dbp_defs.svh"

// Behaviour
// - direction one makes pin tri-stated input
// - direction zero drives pin from latch
// - data read returns sampled pin levels
// - data write is read-modify-write into latch
// - direction still gates drivers on analog pins
// - analog pins read as zero
// - low power mode reads port C direction bits 1:0 one
// - power-on sets directions one, data undefined
// - warm reset keeps data, directions to one
// - port C bits 0,1 timer osc or capture
// - port C bit 2 pwm or capture
// - port C bits 3-5 serial port
// - port C bits 6,7 uart
// - port D bits 4:0 plain I/O only
// - port D bits 5-7 pwm steering
module dbp_top (
  // clock and resets
  input wire logic CLK_I,
  input wire logic RSTN_I,
  input wire logic WARM_RST_I,
  // register port
  input wire logic [3:0] ADDR_I,
  input wire logic [7:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [7:0] RDATA_O,
  // oscillator mode
  input wire logic LOW_POWER_CRYSTAL_MODE_I,
  // port pins
  input wire logic [7:0] PC_PIN_I,
  output logic [7:0] PC_PIN_O,
  output logic [7:0] PC_PIN_OE_O,
  input wire logic [7:0] PD_PIN_I,
  output logic [7:0] PD_PIN_O,
  output logic [7:0] PD_PIN_OE_O,
  // secondary timer oscillator
  input wire logic SEC_TIMER_OSC_EN_I,
  input wire logic SEC_TIMER_OSC_OUT_I,
  output logic SEC_TIMER_CLOCK_IN_O,
  output logic SEC_TIMER_OSC_IN_O,
  // capture/compare units
  input wire logic FIRST_CAPTURE_COMPARE_SEL_I,
  input wire logic FIRST_CAPTURE_COMPARE_PIN_I,
  input wire logic FIRST_CAPTURE_COMPARE_OE_I,
  output logic FIRST_CAPTURE_COMPARE_PIN_O,
  input wire logic SECOND_CAPTURE_COMPARE_SEL_I,
  input wire logic SECOND_CAPTURE_COMPARE_PIN_I,
  input wire logic SECOND_CAPTURE_COMPARE_OE_I,
  output logic SECOND_CAPTURE_COMPARE_PIN_O,
  // pwm steering outputs b..d on port D
  input wire logic [2:0] PWM_STEER_SEL_I,
  input wire logic [2:0] PWM_STEER_OUT_I,
  // synchronous serial port
  input wire logic SSP_SEL_I,
  input wire logic SSP_CLK_I,
  input wire logic SSP_CLK_OE_I,
  input wire logic SSP_DATA_OE_I,
  input wire logic SYNC_PORT_DATA_OUT_I,
  output logic SSP_CLK_O,
  output logic SYNC_PORT_DATA_IN_O,
  // uart
  input wire logic UART_SEL_I,
  input wire logic UART_TX_I,
  input wire logic UART_TX_OE_I,
  input wire logic UART_SYNC_DATA_I,
  input wire logic UART_SYNC_DATA_OE_I,
  output logic UART_SYNC_CLOCK_O,
  output logic UART_SYNC_DATA_O
);

  // ==========================================================
  // register state
  dbp_pkg::dbp_byte_type c_lat_q;
  dbp_pkg::dbp_byte_type d_lat_q;
  dbp_pkg::dbp_byte_type c_dir_q;
  dbp_pkg::dbp_byte_type d_dir_q;
  dbp_pkg::dbp_byte_type c_ana_q;
  dbp_pkg::dbp_byte_type d_ana_q;
  logic cold_q;
  logic [7:0] rmux;
  logic [7:0] c_out;
  logic [7:0] c_oe;
  logic [7:0] d_out;
  logic [7:0] d_oe;
  logic [7:0] c_sel;
  logic [7:0] c_per_out;
  logic [7:0] c_per_oe;
  logic [7:0] d_sel;
  logic [7:0] d_per_out;
  logic [7:0] d_per_oe;
  logic [7:0] status;

  // read-modify-write: merge new bits over sampled pins
  function automatic logic [7:0] rmw(input logic [7:0] pins,
                                     input logic [7:0] nv,
                                     input logic [7:0] msk);
    rmw = (pins & ~msk) | (nv & msk);
  endfunction

  // ==========================================================
  // data latches
  // no async reset: power-on value undefined, warm reset keeps it
  // data kept
  // write through rmw, whole byte modified
  always_ff @(posedge CLK_I) begin
    if (WR_I && ADDR_I == `DBP_ADDR_C_DATA) begin
      c_lat_q <= rmw(PC_PIN_I, WDATA_I, 8'hFF);
    end
    if (WR_I && ADDR_I == `DBP_ADDR_D_DATA) begin
      d_lat_q <= rmw(PD_PIN_I, WDATA_I, 8'hFF);
    end
  end

  // ==========================================================
  // direction registers
  // directions to ones
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      c_dir_q <= `DBP_DIR_RESET;
      d_dir_q <= `DBP_DIR_RESET;
    end else if (WARM_RST_I) begin
      c_dir_q <= `DBP_DIR_RESET;
      d_dir_q <= `DBP_DIR_RESET;
    end else if (WR_I) begin
      if (ADDR_I == `DBP_ADDR_C_DIR) begin
        c_dir_q <= WDATA_I;
      end
      if (ADDR_I == `DBP_ADDR_D_DIR) begin
        d_dir_q <= WDATA_I;
      end
    end
  end

  // analog select, plus cold flag showing no data write since power-on
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      c_ana_q <= `DBP_ANALOG_RESET;
      d_ana_q <= `DBP_ANALOG_RESET;
      cold_q <= 1'b1;
    end else if (WR_I) begin
      if (ADDR_I == `DBP_ADDR_C_ANALOG) begin
        c_ana_q <= WDATA_I;
      end
      if (ADDR_I == `DBP_ADDR_D_ANALOG) begin
        d_ana_q <= WDATA_I;
      end
      if (ADDR_I == `DBP_ADDR_C_DATA || ADDR_I == `DBP_ADDR_D_DATA) begin
        cold_q <= 1'b0;
      end
    end
  end

  // ==========================================================
  // peripheral claims on port C
  always_comb begin
    c_sel = 8'h00;
    c_per_out = 8'h00;
    c_per_oe = 8'h00;
    if (SEC_TIMER_OSC_EN_I) begin
      c_sel[0] = 1'b1;
      c_per_out[0] = SEC_TIMER_OSC_OUT_I;
      c_per_oe[0] = 1'b1;
      c_sel[1] = 1'b1;
    end else if (SECOND_CAPTURE_COMPARE_SEL_I) begin
      c_sel[1] = 1'b1;
      c_per_out[1] = SECOND_CAPTURE_COMPARE_PIN_I;
      c_per_oe[1] = SECOND_CAPTURE_COMPARE_OE_I;
    end
    if (FIRST_CAPTURE_COMPARE_SEL_I) begin
      c_sel[2] = 1'b1;
      c_per_out[2] = FIRST_CAPTURE_COMPARE_PIN_I;
      c_per_oe[2] = FIRST_CAPTURE_COMPARE_OE_I;
    end
    if (SSP_SEL_I) begin
      c_sel[5:3] = 3'b111;
      c_per_out[3] = SSP_CLK_I;
      c_per_oe[3] = SSP_CLK_OE_I;
      c_per_oe[4] = SSP_DATA_OE_I;
      c_per_out[5] = SYNC_PORT_DATA_OUT_I;
      c_per_oe[5] = 1'b1;
    end
    if (UART_SEL_I) begin
      c_sel[7:6] = 2'b11;
      c_per_out[6] = UART_TX_I;
      c_per_oe[6] = UART_TX_OE_I;
      c_per_out[7] = UART_SYNC_DATA_I;
      c_per_oe[7] = UART_SYNC_DATA_OE_I;
    end
  end

  // port D: low bits stay plain I/O, steering on 7:5
  always_comb begin
    d_sel = {PWM_STEER_SEL_I, 5'h00};
    d_per_out = {PWM_STEER_OUT_I, 5'h00};
    d_per_oe = {3'b111, 5'h00};
  end

  // direction gates drivers regardless of analog use
  dbp_pin_mux #(.WIDTH(8)) u_mux_c (
    .latch_i(c_lat_q),
    .dir_i(c_dir_q),
    .per_sel_i(c_sel),
    .per_out_i(c_per_out),
    .per_oe_i(c_per_oe),
    .out_o(c_out),
    .oe_o(c_oe)
  );

  dbp_pin_mux #(.WIDTH(8)) u_mux_d (
    .latch_i(d_lat_q),
    .dir_i(d_dir_q),
    .per_sel_i(d_sel),
    .per_out_i(d_per_out),
    .per_oe_i(d_per_oe),
    .out_o(d_out),
    .oe_o(d_oe)
  );

  assign status = {6'h00, cold_q, LOW_POWER_CRYSTAL_MODE_I};

  dbp_read_mux u_rmux (
    .addr_i(ADDR_I),
    .c_pins_i(PC_PIN_I),
    .d_pins_i(PD_PIN_I),
    .c_dir_i(c_dir_q),
    .d_dir_i(d_dir_q),
    .c_ana_i(c_ana_q),
    .d_ana_i(d_ana_q),
    .status_i(status),
    .lp_mode_i(LOW_POWER_CRYSTAL_MODE_I),
    .data_o(rmux)
  );

  // ==========================================================
  // registered outputs, one cycle behind their sources
  // read data only in the cycle after the strobe
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      RDATA_O <= 8'h00;
    end else begin
      RDATA_O <= RD_I ? rmux : 8'h00;
    end
  end

  // pin drive; undriven latch after power-on is masked by oe
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      PC_PIN_O <= 8'h00;
      PC_PIN_OE_O <= 8'h00;
      PD_PIN_O <= 8'h00;
      PD_PIN_OE_O <= 8'h00;
    end else begin
      PC_PIN_O <= c_out & c_oe;
      PC_PIN_OE_O <= c_oe;
      PD_PIN_O <= d_out & d_oe;
      PD_PIN_OE_O <= d_oe;
    end
  end

  // pin levels handed to the peripherals
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      SEC_TIMER_CLOCK_IN_O <= 1'b0;
      SEC_TIMER_OSC_IN_O <= 1'b0;
      FIRST_CAPTURE_COMPARE_PIN_O <= 1'b0;
      SECOND_CAPTURE_COMPARE_PIN_O <= 1'b0;
      SSP_CLK_O <= 1'b0;
      SYNC_PORT_DATA_IN_O <= 1'b0;
      UART_SYNC_CLOCK_O <= 1'b0;
      UART_SYNC_DATA_O <= 1'b0;
    end else begin
      SEC_TIMER_CLOCK_IN_O <= PC_PIN_I[0];
      SEC_TIMER_OSC_IN_O <= PC_PIN_I[1];
      SECOND_CAPTURE_COMPARE_PIN_O <= PC_PIN_I[1];
      FIRST_CAPTURE_COMPARE_PIN_O <= PC_PIN_I[2];
      SSP_CLK_O <= PC_PIN_I[3];
      SYNC_PORT_DATA_IN_O <= PC_PIN_I[4];
      UART_SYNC_CLOCK_O <= PC_PIN_I[6];
      UART_SYNC_DATA_O <= PC_PIN_I[7];
    end
  end

  // ==========================================================
  // assertions and cover properties
  property p_dir_in_tristate;
    @(posedge CLK_I) disable iff (!RSTN_I)
    (c_dir_q[0] && !SEC_TIMER_OSC_EN_I) |=> !PC_PIN_OE_O[0];
  endproperty
  a_dir_in_tristate: assert property (p_dir_in_tristate)
    else $error("input pin driven");

  property p_dir_out_drive;
    @(posedge CLK_I) disable iff (!RSTN_I)
    (!d_dir_q[0]) |=> (PD_PIN_OE_O[0] && PD_PIN_O[0] == $past(d_lat_q[0]));
  endproperty
  a_dir_out_drive: assert property (p_dir_out_drive)
    else $error("output pin not driven from latch");

  property p_read_pins;
    @(posedge CLK_I) disable iff (!RSTN_I)
    (RD_I && ADDR_I == `DBP_ADDR_D_DATA && d_ana_q == 8'h00)
      |=> RDATA_O == $past(PD_PIN_I);
  endproperty
  a_read_pins: assert property (p_read_pins)
    else $error("data read not pin levels");

  property p_rmw_write;
    @(posedge CLK_I) disable iff (!RSTN_I)
    (WR_I && ADDR_I == `DBP_ADDR_C_DATA) |=> c_lat_q == $past(WDATA_I);
  endproperty
  a_rmw_write: assert property (p_rmw_write)
    else $error("latch not written");

  property p_analog_zero;
    @(posedge CLK_I) disable iff (!RSTN_I)
    (RD_I && ADDR_I == `DBP_ADDR_C_DATA)
      |=> (RDATA_O & $past(c_ana_q)) == 8'h00;
  endproperty
  a_analog_zero: assert property (p_analog_zero)
    else $error("analog pin read nonzero");

  property p_low_pwr_dir;
    @(posedge CLK_I) disable iff (!RSTN_I)
    (RD_I && ADDR_I == `DBP_ADDR_C_DIR && LOW_POWER_CRYSTAL_MODE_I)
      |=> RDATA_O[1:0] == 2'b11;
  endproperty
  a_low_pwr_dir: assert property (p_low_pwr_dir)
    else $error("low power direction read wrong");

  property p_warm_dir;
    @(posedge CLK_I) disable iff (!RSTN_I)
    WARM_RST_I |=> (c_dir_q == 8'hFF && d_dir_q == 8'hFF);
  endproperty
  a_warm_dir: assert property (p_warm_dir)
    else $error("warm reset left direction");

  property p_steer;
    @(posedge CLK_I) disable iff (!RSTN_I)
    PWM_STEER_SEL_I[0] |=> (PD_PIN_OE_O[5]
      && PD_PIN_O[5] == $past(PWM_STEER_OUT_I[0]));
  endproperty
  a_steer: assert property (p_steer)
    else $error("steering output not on pin");

  property p_plain_d;
    @(posedge CLK_I) disable iff (!RSTN_I)
    1'b1 |=> PD_PIN_OE_O[4:0] == ~$past(d_dir_q[4:0]);
  endproperty
  a_plain_d: assert property (p_plain_d)
    else $error("low port D bits claimed");

  property p_c_read;
    @(posedge CLK_I) disable iff (!RSTN_I)
    RD_I && ADDR_I == `DBP_ADDR_C_DATA;
  endproperty
  c_c_read: cover property (p_c_read);

  property p_uart_claim;
    @(posedge CLK_I) disable iff (!RSTN_I)
    UART_SEL_I ##1 PC_PIN_OE_O[6];
  endproperty
  c_uart_claim: cover property (p_uart_claim);

  property p_wr_then_rd;
    @(posedge CLK_I) disable iff (!RSTN_I)
    (WR_I && ADDR_I == `DBP_ADDR_D_DIR) ##1 RD_I;
  endproperty
  c_wr_then_rd: cover property (p_wr_then_rd);
endmodule

`default_nettype wire

// ---- bench/dbp_pin_model.sv ----
`default_nettype none

// ==========================================================
// outside world at the port pins
module dbp_pin_model #(
  parameter int WIDTH = 16
) (
  // clock
  input wire logic clk_i,
  // drive from the block
  input wire logic [WIDTH-1:0] out_i,
  input wire logic [WIDTH-1:0] oe_i,
  // drive from the board
  input wire logic [WIDTH-1:0] ext_i,
  input wire logic [WIDTH-1:0] ext_en_i,
  // resolved pin levels
  output logic [WIDTH-1:0] pin_o
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [WIDTH-1:0] last_q = '0;

  // a floating pin shows the inverse of its last level, so a read of
  // an undriven pin can never match a stale value by luck
  always_comb begin
    pin_o = (oe_i & out_i) | (~oe_i & ext_en_i & ext_i);
    pin_o = pin_o | (~oe_i & ~ext_en_i & ~last_q);
  end

  // last level seen on each pin
  always_ff @(posedge clk_i) begin
    last_q <= pin_o;
  end
endmodule

`default_nettype wire

// ---- bench/test_dbp_top.sv ----
`default_nettype none
`include "dbp_defs.svh"

module test_dbp_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic warm = 1'b0;
  logic lowpwr = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic rd_p1 = 1'b0;
  logic [7:0] rdata;
  logic [23:0] pv = 24'h000000;
  logic [15:0] ext = 16'h0000;
  logic [15:0] ext_en = 16'h0000;
  logic [15:0] pout, poe, pin;
  logic [7:0] sense;
  logic [7:0] rnd = 8'h5A;
  logic [7:0] lc, ld, oc, xc;
  logic [7:0] exp_q[$];
  int fail_count = 0;
  int checks_done = 0;
  int cyc = 0;

  always #5 clk = ~clk;

  // ==========================================================
  // block and pins
  dbp_top dbp_top_i (
    .CLK_I(clk), .RSTN_I(rstn), .WARM_RST_I(warm),
    .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr_s), .RD_I(rd_s),
    .RDATA_O(rdata), .LOW_POWER_CRYSTAL_MODE_I(lowpwr),
    .PC_PIN_I(pin[7:0]), .PC_PIN_O(pout[7:0]), .PC_PIN_OE_O(poe[7:0]),
    .PD_PIN_I(pin[15:8]), .PD_PIN_O(pout[15:8]),
    .PD_PIN_OE_O(poe[15:8]),
    .SEC_TIMER_OSC_EN_I(pv[0]), .SEC_TIMER_OSC_OUT_I(pv[1]),
    .SEC_TIMER_CLOCK_IN_O(sense[0]), .SEC_TIMER_OSC_IN_O(sense[1]),
    .FIRST_CAPTURE_COMPARE_SEL_I(pv[2]),
    .FIRST_CAPTURE_COMPARE_PIN_I(pv[3]),
    .FIRST_CAPTURE_COMPARE_OE_I(pv[4]),
    .FIRST_CAPTURE_COMPARE_PIN_O(sense[3]),
    .SECOND_CAPTURE_COMPARE_SEL_I(pv[5]),
    .SECOND_CAPTURE_COMPARE_PIN_I(pv[6]),
    .SECOND_CAPTURE_COMPARE_OE_I(pv[7]),
    .SECOND_CAPTURE_COMPARE_PIN_O(sense[2]),
    .PWM_STEER_SEL_I(pv[20:18]), .PWM_STEER_OUT_I(pv[23:21]),
    .SSP_SEL_I(pv[8]), .SSP_CLK_I(pv[9]), .SSP_CLK_OE_I(pv[10]),
    .SSP_DATA_OE_I(pv[11]), .SYNC_PORT_DATA_OUT_I(pv[12]),
    .SSP_CLK_O(sense[4]), .SYNC_PORT_DATA_IN_O(sense[5]),
    .UART_SEL_I(pv[13]), .UART_TX_I(pv[14]), .UART_TX_OE_I(pv[15]),
    .UART_SYNC_DATA_I(pv[16]), .UART_SYNC_DATA_OE_I(pv[17]),
    .UART_SYNC_CLOCK_O(sense[6]), .UART_SYNC_DATA_O(sense[7])
  );

  dbp_pin_model #(.WIDTH(16)) dbp_pin_model_i (
    .clk_i(clk), .out_i(pout), .oe_i(poe), .ext_i(ext),
    .ext_en_i(ext_en), .pin_o(pin)
  );

  // ==========================================================
  // helpers
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task automatic nxt();
    rnd = lfsr(rnd);
  endtask

  task automatic check(input string name, input logic [7:0] seen,
                       input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask

  // the expected word is noted when the read is issued
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    exp_q.push_back(e);
    @(posedge clk);
    rd_s <= 1'b0;
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // read data stands only in the cycle after the strobe
  always @(posedge clk) begin
    rd_p1 <= rd_s;
    if (rd_p1) begin
      check("rdata", rdata, exp_q.pop_front());
    end
  end

  // hang guard, far above the sixty or so cycles the tests need
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      results();
    end
  end

  // ==========================================================
  // main sequence
  initial begin
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    rd(`DBP_ADDR_C_DIR, 8'hFF);
    rd(`DBP_ADDR_D_DIR, 8'hFF);
    rd(4'hF, 8'h00);
    settle(2);
    check("oe after reset", poe[7:0] | poe[15:8], 8'h00);
    $display("test reset done");
    nxt();
    ld = rnd;
    // latch first: an output must never show the undefined power-on latch
    wr(`DBP_ADDR_D_DATA, ld);
    wr(`DBP_ADDR_D_DIR, 8'h00);
    settle(2);
    check("d oe", poe[15:8], 8'hFF);
    check("d out", pout[15:8], ld);
    rd(`DBP_ADDR_D_DATA, ld);
    $display("test output done");
    nxt();
    ext <= {8'h00, rnd};
    ext_en <= 16'h00FF;
    rd(`DBP_ADDR_C_DATA, rnd);
    // analog pins kept as inputs on port C
    wr(`DBP_ADDR_C_ANALOG, 8'h0F);
    rd(`DBP_ADDR_C_DATA, rnd & 8'hF0);
    wr(`DBP_ADDR_D_ANALOG, 8'hFF);
    rd(`DBP_ADDR_D_DATA, 8'h00);
    settle(2);
    check("analog drive", poe[15:8], 8'hFF);
    $display("test input done");
    nxt();
    lc = rnd;
    xc = ext[7:0];
    wr(`DBP_ADDR_C_DATA, lc);
    lowpwr <= 1'b1;
    wr(`DBP_ADDR_C_DIR, 8'h00);
    rd(`DBP_ADDR_C_DIR, 8'h03);
    lowpwr <= 1'b0;
    rd(`DBP_ADDR_C_DIR, 8'h00);
    $display("test low power done");
    warm <= 1'b1;
    @(posedge clk);
    warm <= 1'b0;
    settle(2);
    check("warm oe", poe[15:8], 8'h00);
    wr(`DBP_ADDR_D_DIR, 8'h00);
    settle(2);
    check("warm latch", pout[15:8], ld);
    wr(`DBP_ADDR_C_DIR, 8'h00);
    $display("test warm reset done");
    // every port C and D peripheral claims its pins, oscillator off
    nxt();
    pv[7:0] <= rnd | 8'h24;
    nxt();
    pv[15:8] <= rnd | 8'h21;
    nxt();
    pv[23:16] <= {rnd[7:5], 3'h7, rnd[1:0]};
    settle(3);
    pv[0] <= 1'b0;
    settle(3);
    oc = {pv[17], pv[15], 1'b1, pv[11], pv[10], pv[4], pv[7], 1'b1};
    check("c oe", poe[7:0], oc);
    check("c out", pout[7:0], oc & {pv[16], pv[14], pv[12], 1'b0,
      pv[9], pv[3], pv[6], lc[0]});
    check("d out", pout[15:8], {pv[23:21], ld[4:0]});
    xc = (oc & pout[7:0]) | (~oc & xc);
    check("sense", sense, {xc[7:6], xc[4:3], xc[2], xc[1], xc[1],
      xc[0]});
    pv[0] <= 1'b1;
    settle(3);
    check("osc oe", poe[7:0] & 8'h03, 8'h01);
    check("osc out", pout[7:0] & 8'h03, {7'h00, pv[1]});
    $display("test peripherals done");
    settle(2);
    results();
  end
endmodule

`default_nettype wire
